// ### hw/tim_pkg.sv
// Shared constants and carrier types for the tone and interrupt mask block
package tim_pkg;

	// Register addresses on the serial control bus
	localparam logic [7:0]  ADDR_TONE       = 8'hCD;
	localparam logic [7:0]  ADDR_MASK       = 8'hCE;
	localparam logic [7:0]  ADDR_STATUS     = 8'hC6;
	localparam logic [7:0]  ADDR_PROG       = 8'hC8;

	// Field positions
	localparam int          FREQ_W          = 12;
	localparam int          MASK_GLOBAL_BIT = 15;
	localparam int          STAT_IRQ_BIT    = 15;
	localparam int          STAT_PROG_BIT   = 0;

	// Reset values
	localparam logic [15:0] TONE_RESET      = 16'h0000;
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	localparam logic [15:0] STATUS_RESET    = 16'h0000;

	// Implemented bit positions, others read and act as zero; then the status bits that a read keeps
	localparam logic [15:0] MASK_ASSIGNED   = 16'hBFD9;
	localparam logic [15:0] STAT_ASSIGNED   = 16'hBFF9;
	localparam logic [15:0] STAT_KEEP_READ  = 16'h0001;

	// Serial frame layout
	localparam int          ADDR_BITS       = 8;
	localparam int          DATA_BITS       = 16;

	// Timing
	localparam int          CLK_PERIOD_NS   = 40;
	localparam int          CLK_HZ          = 1_000_000_000 / CLK_PERIOD_NS;
	localparam int          ACC_W           = 25;

	typedef enum logic [1:0] {
		TIM_SER_IDLE = 2'b00,
		TIM_SER_ADDR = 2'b01,
		TIM_SER_DATA = 2'b10
	} tim_ser_state_t;

	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic cmd;
	} tim_ser_t;

	typedef struct packed {
		logic tone_en;
		logic tx_mode;
		logic to_speaker;
		logic to_mod;
	} tim_route_t;

endpackage

// ### hw/tim_serial_slave.sv
// Serial control bus slave: 8 address bits then 16 data bits, MSB first
`timescale 1ns/1ps

module tim_serial_slave (
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire tim_pkg::tim_ser_t ser_in,
	input  wire logic [15:0]       reply_word_in,
	output logic                   reply_out,
	output logic [7:0]             addr_out,
	output logic [15:0]            data_out,
	output logic                   frame_done_out
);

	tim_pkg::tim_ser_state_t state_r;
	logic        sclk_d_r;
	logic        sel_d_r;
	logic [4:0]  cnt_r;
	logic [15:0] reply_sh_r;
	logic        rise;
	logic        fall;
	logic        sel_end;

	assign rise    = ser_in.sclk & ~sclk_d_r & ~ser_in.sel_n;
	assign fall    = ~ser_in.sclk & sclk_d_r & ~ser_in.sel_n;
	assign sel_end = ser_in.sel_n & ~sel_d_r;
	assign reply_out = reply_sh_r[15];

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sclk_d_r <= 1'b0;
			sel_d_r  <= 1'b1;
		end else begin
			sclk_d_r <= ser_in.sclk;
			sel_d_r  <= ser_in.sel_n;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_r    <= tim_pkg::TIM_SER_IDLE;
			cnt_r      <= 5'h00;
			addr_out   <= 8'h00;
			data_out   <= 16'h0000;
			reply_sh_r <= 16'h0000;
		end else if (ser_in.sel_n) begin
			state_r    <= tim_pkg::TIM_SER_IDLE;
			cnt_r      <= 5'h00;
			reply_sh_r <= 16'h0000;
		end else begin
			case (state_r)
				tim_pkg::TIM_SER_IDLE: begin
					state_r <= tim_pkg::TIM_SER_ADDR;
					cnt_r   <= 5'h00;
				end
				tim_pkg::TIM_SER_ADDR: begin
					if (rise) begin
						addr_out <= {addr_out[6:0], ser_in.cmd};
						if (cnt_r == 5'(tim_pkg::ADDR_BITS - 1)) begin
							state_r <= tim_pkg::TIM_SER_DATA;
							cnt_r   <= 5'h00;
						end else begin
							cnt_r <= cnt_r + 5'h01;
						end
					end
				end
				tim_pkg::TIM_SER_DATA: begin
					// Reply word captured just after the address; its first bit drives at once, later bits shift out on falls
					if (cnt_r == 5'h00 && !rise && !fall && reply_sh_r == 16'h0000)
						reply_sh_r <= reply_word_in;
					if (rise && cnt_r != 5'(tim_pkg::DATA_BITS)) begin
						data_out <= {data_out[14:0], ser_in.cmd};
						cnt_r    <= cnt_r + 5'h01;
					end
					if (fall && cnt_r != 5'h00)
						reply_sh_r <= {reply_sh_r[14:0], 1'b0};
				end
				default: state_r <= tim_pkg::TIM_SER_IDLE;
			endcase
		end
	end

	// A frame counts only when all 24 bits arrived before select rose
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			frame_done_out <= 1'b0;
		else
			frame_done_out <= sel_end && state_r == tim_pkg::TIM_SER_DATA
				&& cnt_r == 5'(tim_pkg::DATA_BITS);
	end

endmodule

// ### hw/tim_regs.sv
// Tone frequency word, interrupt mask, status summary and tone generator
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// How it works
// [RL1] The tone frequency in hertz equals the low 12 bits of the tone word.
// [RL2] A tone is produced only while the mode control tone enable is set.
// [RL3] An enabled tone with frequency zero leaves the output at bias.
// [RL4] The host programs only 300 Hz to 3000 Hz when generating a tone.
// [RL5] The host silences other signalling and sets routing around a tone.
// [RL6] The tone word may be rewritten mid-tone; it applies when the write ends.
// [RL7] The tone routes to the speaker in either mode or to the modulator in transmit.
// [RL8] Mask bit 15 is the global enable; when clear the interrupt pin never asserts.
// [RL9] The host writes zero to mask bit 14 and other unassigned mask bits.
// [RL10] Mask bit 13 gates an interrupt on a rise of status bit 13.
// [RL11] Mask bit 12 gates an interrupt on a rise of status bit 12.
// [RL12] Mask bit 11 gates an interrupt on a rise of status bit 11.
// [RL13] Mask bits 10, 9 and 8 gate the status bits at the same positions.
// [RL14] Mask bits 7, 6, 4, 3 and 0 gate the status bits at the same positions.
// [RL15] A status change sets summary bit 15 only when its mask bit is set.
// [RL16] The interrupt pin asserts low when summary and global mask are both set.
// [RL17] A status read clears bits 1 to 15; bit 0 clears on a programming write.
module tim_regs (
	input  wire logic                clk_sys_in,
	input  wire logic                rst_n_in,
	input  wire tim_pkg::tim_ser_t   ser_in,
	input  wire tim_pkg::tim_route_t route_in,
	input  wire logic [15:0]         status_set_in,
	output logic                     reply_out,
	output logic                     interrupt_request_pin_n_out,
	output logic                     speaker_tone_out,
	output logic                     modulator_outputs_tone_out,
	output logic                     tone_bias_out,
	output logic [15:0]              status_out
);

	logic [7:0]  addr;
	logic [15:0] wdata;
	logic        frame_done;
	logic        reply_bit;
	logic [15:0] tone_word_r;
	logic [15:0] mask_r;
	logic [15:0] status_r;
	logic [15:0] status_nxt;
	logic [15:0] ev;
	logic        wr_tone;
	logic        wr_mask;
	logic        wr_prog;
	logic        rd_status;
	logic [tim_pkg::ACC_W-1:0] acc_r;
	logic [tim_pkg::ACC_W-1:0] sum;
	logic        wave_r;
	logic        tone_on;
	logic        wrap;
	logic        irq_cond;
	logic [15:0] set_ok;
	logic [tim_pkg::ACC_W-1:0] step;

	// Accumulator wraps at the clock rate; its width leaves headroom above
	// that rate, so adding a full step to any kept value cannot overflow
	localparam int                        WRAP_I = tim_pkg::CLK_HZ;
	localparam logic [tim_pkg::ACC_W-1:0] WRAP   = WRAP_I[tim_pkg::ACC_W-1:0];

	//////////////////////////////////////////////////////////////////////////
	// Serial bus

	// The reply shifter takes the status word just after the address, and the
	// read clear lands at frame end: a flag in bits 1 to 15 raised in between is
	// never seen by the host, which is the price of clearing on the whole frame
	tim_serial_slave u_ser (
		.clk_sys_in     (clk_sys_in),
		.rst_n_in       (rst_n_in),
		.ser_in         (ser_in),
		.reply_word_in  (status_r),
		.reply_out      (reply_bit),
		.addr_out       (addr),
		.data_out       (wdata),
		.frame_done_out (frame_done)
	);

	assign reply_out = reply_bit;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// Acting only at frame end makes a new frequency take hold after the write
	assign wr_tone   = frame_done & hit(addr, tim_pkg::ADDR_TONE);      // [RL6]
	assign wr_mask   = frame_done & hit(addr, tim_pkg::ADDR_MASK);
	assign wr_prog   = frame_done & hit(addr, tim_pkg::ADDR_PROG);
	assign rd_status = frame_done & hit(addr, tim_pkg::ADDR_STATUS);

	//////////////////////////////////////////////////////////////////////////
	// Write-only registers

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			tone_word_r <= tim_pkg::TONE_RESET;
		else if (wr_tone)
			tone_word_r <= wdata;                                          // [RL6]
	end

	// Unassigned positions are dropped on entry, so no stray bit gates a source
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			mask_r <= tim_pkg::MASK_RESET;
		else if (wr_mask)
			mask_r <= wdata & tim_pkg::MASK_ASSIGNED;                      // [RL9]
	end

	//////////////////////////////////////////////////////////////////////////
	// Status and interrupt summary

	// One gate per status position. The summary position is left out of both
	// vectors so that only the gated events below can ever set it.
	for (genvar gi = 0; gi < 16; gi++) begin : g_gate
		if (gi == tim_pkg::STAT_IRQ_BIT) begin : g_sum
			assign set_ok[gi] = 1'b0;
			assign ev[gi]     = 1'b0;
		end else begin : g_flag
			// Reserved positions read as zero and can never raise the pin
			assign set_ok[gi] = status_set_in[gi] & tim_pkg::STAT_ASSIGNED[gi];
			assign ev[gi]     = set_ok[gi] & mask_r[gi];  // [RL10] [RL11] [RL12] [RL13] [RL14]
		end
	end

	always_comb begin
		status_nxt = status_r;
		if (rd_status)
			status_nxt = status_nxt & tim_pkg::STAT_KEEP_READ;             // [RL17]
		if (wr_prog)
			status_nxt[tim_pkg::STAT_PROG_BIT] = 1'b0;                     // [RL17]
		// Sets are applied last so a coincident event survives the clear
		status_nxt = status_nxt | set_ok;
		if (|ev)
			status_nxt[tim_pkg::STAT_IRQ_BIT] = 1'b1;                      // [RL15]
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			status_r <= tim_pkg::STATUS_RESET;
		else
			status_r <= status_nxt;
	end

	assign status_out = status_r;

	// The global enable gates only the pin: a summary bit set under a clear
	// global enable still stands in the status word for the host to poll
	assign irq_cond = status_r[tim_pkg::STAT_IRQ_BIT]
		& mask_r[tim_pkg::MASK_GLOBAL_BIT];                               // [RL8] [RL16]

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			interrupt_request_pin_n_out <= 1'b1;
		else
			interrupt_request_pin_n_out <= ~irq_cond;                      // [RL16]
	end

	//////////////////////////////////////////////////////////////////////////
	// Tone generator

	// Zero frequency keeps bias even while enabled
	assign tone_on = route_in.tone_en
		&& tone_word_r[tim_pkg::FREQ_W-1:0] != 12'h000;                   // [RL2] [RL3]

	// Adds twice the frequency per cycle and wraps at the clock rate: each
	// wrap is a half period, so the mean rate is exact at 1 Hz per step
	assign step = {12'h000, tone_word_r[tim_pkg::FREQ_W-1:0], 1'b0};         // [RL1]
	assign sum  = acc_r + step;

	// A retune keeps the accumulator, so the pitch changes without a phase
	// jump; a stop clears it so every tone starts from the same point
	assign wrap = sum >= WRAP;

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			acc_r <= '0;
		else if (!tone_on)
			acc_r <= '0;
		else if (wrap)
			acc_r <= sum - WRAP;                                           // [RL1]
		else
			acc_r <= sum;
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			wave_r <= 1'b0;
		else if (!tone_on)
			wave_r <= 1'b0;
		else if (wrap)
			wave_r <= ~wave_r;                                             // [RL1]
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			speaker_tone_out <= 1'b0;
		else
			speaker_tone_out <= tone_on & route_in.to_speaker & wave_r;        // [RL7]
	end

	// The modulator path carries the tone only in transmit
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			modulator_outputs_tone_out <= 1'b0;
		else
			modulator_outputs_tone_out <= tone_on & route_in.to_mod
				& route_in.tx_mode & wave_r;                                   // [RL7]
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in)
			tone_bias_out <= 1'b1;
		else
			tone_bias_out <= ~tone_on;                                     // [RL3]
	end

endmodule

// ### sim/tim_regs_sva.sv
// Assertion checker for the tone and interrupt mask block
`timescale 1ns/1ps
module tim_regs_sva (
	input wire logic                clk_sys_in,
	input wire logic                rst_n_in,
	input wire tim_pkg::tim_ser_t   ser_in,
	input wire tim_pkg::tim_route_t route_in,
	input wire logic [15:0]         status_set_in,
	input wire logic                reply_out,
	input wire logic                interrupt_request_pin_n_out,
	input wire logic                speaker_tone_out,
	input wire logic                modulator_outputs_tone_out,
	input wire logic                tone_bias_out,
	input wire logic [15:0]         status_out
);
	default clocking dcb @(posedge clk_sys_in);
	endclocking
	default disable iff (!rst_n_in);
	a_irq_release: assert property (!status_out[15] |=> interrupt_request_pin_n_out)
		else $error("irq pin low without summary bit");
	a_stat_set: assert property (status_set_in[13] |=> status_out[13])
		else $error("status bit 13 not set");
	a_set_bit0: assert property (status_set_in[0] |=> status_out[0])
		else $error("status bit 0 not set");
	a_sum_cause: assert property ($rose(status_out[15]) |-> $past(status_set_in) != 16'h0000)
		else $error("summary bit rose with no event");
	// Bits may only fall at a frame end, so a quiet bus must hold them
	a_stat_hold: assert property (ser_in.sel_n [*4] |=>
		(status_out & $past(status_out)) == $past(status_out))
		else $error("status bit lost without a frame");
	a_reply_idle: assert property (ser_in.sel_n [*2] |-> !reply_out)
		else $error("reply driven while deselected");
	a_tone_idle: assert property (!route_in.tone_en [*3] |->
		tone_bias_out && !speaker_tone_out && !modulator_outputs_tone_out)
		else $error("tone present while disabled");
	a_mod_tx: assert property (modulator_outputs_tone_out |->
		$past(route_in.tx_mode) || $past(route_in.tx_mode, 2))
		else $error("modulator tone outside transmit");
	a_spk_route: assert property (speaker_tone_out |->
		$past(route_in.to_speaker) || $past(route_in.to_speaker, 2))
		else $error("speaker tone without route");
	c_irq: cover property (!interrupt_request_pin_n_out);
	c_tone: cover property ($rose(speaker_tone_out));
	c_clear: cover property ($fell(status_out[15]));
endmodule
bind tim_regs tim_regs_sva i_sva (.clk_sys_in, .rst_n_in, .ser_in, .route_in, .status_set_in,
	.reply_out, .interrupt_request_pin_n_out, .speaker_tone_out, .modulator_outputs_tone_out,
	.tone_bias_out, .status_out);

// ### sim/tim_host_model.sv
// Host microcontroller model driving the serial control bus
`timescale 1ns/1ps
module tim_host_model (
	input  wire logic         clk_sys_in,
	input  wire logic         reply_in,
	output tim_pkg::tim_ser_t ser_out
);
	logic [15:0] rd_r;
	initial ser_out = '{1'b1, 1'b0, 1'b0};
	task automatic xfer(input logic [7:0] addr, input logic [15:0] data);
		logic [23:0] w;
		w = {addr, (addr == tim_pkg::ADDR_MASK) ? data & tim_pkg::MASK_ASSIGNED : data};
		@(posedge clk_sys_in) ser_out.sel_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			ser_out.sclk <= 1'b0;
			ser_out.cmd  <= w[i];
			repeat (2) @(posedge clk_sys_in);
			ser_out.sclk <= 1'b1;
			@(posedge clk_sys_in);
			if (i < 16) rd_r[i] = reply_in;
			@(posedge clk_sys_in);
		end
		ser_out.sclk  <= 1'b0;
		ser_out.sel_n <= 1'b1;
		ser_out.cmd   <= ~w[0]; // Driven to the inverse of the last bit, no stale level
		repeat (5) @(posedge clk_sys_in);
	endtask
endmodule

// ### sim/tb_tone_and_irq_mask_regs.sv
// Self-checking bench for the tone and interrupt mask block
`timescale 1ns/1ps
module tb_tone_and_irq_mask_regs;
	typedef struct packed {logic [15:0] mask, set, stat; logic irq_n;} tim_row_t;
	logic                clk_sys_in = 1'b0;
	logic                rst_n_in = 1'b0;
	tim_pkg::tim_ser_t   ser;
	tim_pkg::tim_route_t route_r = '0;
	logic [15:0]         set_r = '0;
	logic [15:0]         stat;
	logic                reply, irq_n, spk, modo, bias;
	int                  fails = 0, n_checks = 0, ns, nm, np;
	tim_row_t rows [8] = '{
		'{16'hA000, 16'h2000, 16'hA000, 1'b0}, '{16'h9000, 16'h1000, 16'h9000, 1'b0},
		'{16'h8800, 16'h0800, 16'h8800, 1'b0}, '{16'h8700, 16'h0700, 16'h8700, 1'b0},
		'{16'h7FFF, 16'h2000, 16'hA000, 1'b1}, '{16'h8000, 16'h2000, 16'h2000, 1'b1},
		'{16'hFFFF, 16'h0020, 16'h0020, 1'b1}, '{16'h80D9, 16'h00D9, 16'h80D9, 1'b0}};
	tim_regs i_dut (.clk_sys_in, .rst_n_in, .ser_in(ser), .route_in(route_r),
		.status_set_in(set_r), .reply_out(reply), .interrupt_request_pin_n_out(irq_n),
		.speaker_tone_out(spk), .modulator_outputs_tone_out(modo), .tone_bias_out(bias),
		.status_out(stat));
	tim_host_model i_host (.clk_sys_in, .reply_in(reply), .ser_out(ser));
	always #20 clk_sys_in = ~clk_sys_in;
	////////////////////////////////////////////////////////////////////////////
	task automatic chk16(input string s, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chkn(input string s, input int lo, input int hi, input int g);
		n_checks++;
		if (g < lo || g > hi) begin
			fails++;
			$display("[ERR] %s expected %0d..%0d seen %0d", s, lo, hi, g);
		end
	endtask
	// Skips the route lag, then counts rising edges of both tone outputs
	task automatic count(input int n);
		logic ps, pm;
		repeat (3) @(posedge clk_sys_in);
		ns = 0;
		nm = 0;
		ps = spk;
		pm = modo;
		repeat (n) begin
			@(negedge clk_sys_in);
			ns += int'(spk && !ps);
			nm += int'(modo && !pm);
			ps = spk;
			pm = modo;
		end
	endtask
	// Finds a speaker rise, then counts cycles to the next one into np;
	// modulator rises inside that span land in nm
	task automatic period(input int lim);
		logic ps, pm;
		int   guard;
		ns = 0;
		nm = 0;
		np = 0;
		guard = 0;
		while (ns < 2 && guard < lim) begin
			ps = spk;
			pm = modo;
			@(negedge clk_sys_in);
			guard++;
			if (ns == 1) begin
				np++;
				nm += int'(modo && !pm);
			end
			ns += int'(spk && !ps);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk_sys_in);
		fails++;
		results();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		@(negedge clk_sys_in);
		chk16("reset status", 16'h0000, stat);
		chk16("reset pins", 16'h0003, {14'h0, irq_n, bias});
		foreach (rows[k]) begin
			i_host.xfer(tim_pkg::ADDR_MASK, rows[k].mask);
			@(posedge clk_sys_in) set_r <= rows[k].set;
			@(posedge clk_sys_in) set_r <= '0;
			repeat (3) @(negedge clk_sys_in);
			chk16("status", rows[k].stat, stat);
			chk16("irq pin", {15'h0, rows[k].irq_n}, {15'h0, irq_n});
			i_host.xfer(tim_pkg::ADDR_STATUS, 16'h0000);
			chk16("status read", rows[k].stat, i_host.rd_r);
			@(negedge clk_sys_in);
			chk16("after read", rows[k].stat & 16'h0001, stat);
			chk16("irq after read", 16'h0001, {15'h0, irq_n});
		end
		i_host.xfer(tim_pkg::ADDR_PROG, 16'h0000);
		@(negedge clk_sys_in);
		chk16("prog clear", 16'h0000, stat);
		// Speaker on, receive mode, so the modulator path stays silent
		@(posedge clk_sys_in) route_r <= 4'hB;
		i_host.xfer(tim_pkg::ADDR_TONE, 16'h03E8);
		period(40000);
		chkn("speaker 1000 Hz", tim_pkg::CLK_HZ/1000 - 1, tim_pkg::CLK_HZ/1000 + 1, np);
		chkn("modulator in rx", 0, 0, nm);
		@(posedge clk_sys_in) route_r <= 4'hF;
		i_host.xfer(tim_pkg::ADDR_TONE, 16'h07D0);
		period(40000);
		chkn("speaker 2000 Hz", tim_pkg::CLK_HZ/2000 - 1, tim_pkg::CLK_HZ/2000 + 1, np);
		chkn("modulator in tx", 1, 1, nm);
		i_host.xfer(tim_pkg::ADDR_TONE, 16'h0000);
		count(2000);
		chkn("zero word", 0, 0, ns + nm);
		chk16("zero word pins", 16'h0001, {13'h0, spk, modo, bias});
		i_host.xfer(tim_pkg::ADDR_TONE, 16'h03E8);
		@(posedge clk_sys_in) route_r <= 4'h7;
		count(2000);
		chkn("tone disabled", 0, 0, ns + nm);
		chk16("disabled pins", 16'h0001, {13'h0, spk, modo, bias});
		results();
	end
endmodule
